// file: verilog/hbp_pkg.sv
// Constants, timing counts and types for the dual H-bridge PWM current control.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
// Contract
// R1: Enable low: all drivers off, high-impedance
// R2: Enable high: both H-bridges may conduct
// R3: Never both switches on; interlock dead time
// R4: Short: limit current, then switch transistor off
// R5: Two-bit slope selection for output edges
// R6: Reverse current turns the switch on
// R7: Low-side on-resistance follows range and position
// R8: Comparator continuously feeds digital regulation loop
// R9: PWM switching points aligned to PWM clock
// R10: Selectable PWM frequency doubling
// R11: Selectable artificial PWM frequency jitter
// R12: PWM frequency from internal timing only
// R13: Disabled: loop idle; restart from off
package hbp_pkg;

    localparam int CLK_FREQ_HZ = 20_000_000;
    localparam int CLK_FREQ_MHZ = CLK_FREQ_HZ / 1_000_000;

    // Internal PWM clock grid, all switching points land on it
    localparam int PWM_CLK_PERIOD_NS = 1000;
    localparam int PWM_CLK_CYCLES = (PWM_CLK_PERIOD_NS * CLK_FREQ_MHZ) / 1000;

    // PWM period in PWM clock ticks: 50 ticks of 1 us gives 20 kHz
    localparam int PWM_PERIOD_TICKS = 50;
    localparam int PWM_JITTER_BITS = 3;

    // Interlock dead time, least time so rounded up
    localparam int DEAD_TIME_NS = 250;
    localparam int DEAD_CYCLES_RAW = (DEAD_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int DEAD_CYCLES = (DEAD_CYCLES_RAW < 1) ? 1 : DEAD_CYCLES_RAW;
    localparam int DEAD_W = 4;

    localparam int TICK_W = 5;
    localparam int PER_W = 6;

    // Low-side on-resistance adaptation thresholds
    localparam int RANGE_W = 5;
    localparam int POS_W = 7;
    localparam logic [RANGE_W-1:0] RANGE_LOW_THRESH = 5'h08;
    localparam logic [5:0] AMP_LOW_THRESH = 6'h0c;
    localparam logic [5:0] AMP_FULL = 6'h20;

    localparam int SLOPE_W = 2;
    localparam logic [SLOPE_W-1:0] SLOPE_RESET = 2'h0;

    localparam logic [PWM_JITTER_BITS-1:0] LFSR_SEED = 3'h5;

    localparam int N_WINDINGS = 2;
    localparam int N_HALF = 4;

    typedef enum logic [1:0] {
        REG_OFF,
        REG_FORWARD,
        REG_SLOW,
        REG_FAST
    } hbp_reg_state_t;

endpackage

// file: verilog/hbp_pwm_clock.sv
// Internal PWM clock and PWM period generator with doubling and jitter.
// Assumes only the system clock; no external timing input exists.
`timescale 1ns/100ps
module hbp_pwm_clock
    import hbp_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic freq_double,
    input wire logic jitter_enable,
    output logic pwm_tick,
    output logic period_start
);

    logic [TICK_W-1:0] div_reg;
    logic [PER_W-1:0] tick_cnt_reg;
    logic [PER_W-1:0] period_len_reg;
    logic [PWM_JITTER_BITS-1:0] lfsr_reg;
    logic [PER_W-1:0] base_len;
    logic [PER_W-1:0] next_len;

    // R12: fixed internal divider
    always_ff @(posedge clk)
    begin
        if (srst || div_reg == TICK_W'(PWM_CLK_CYCLES - 1))
            div_reg <= '0;
        else
            div_reg <= div_reg + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            pwm_tick <= 1'b0;
        else
            pwm_tick <= (div_reg == TICK_W'(PWM_CLK_CYCLES - 1));
    end

    // R10: doubling halves the period
    always_comb
    begin
        base_len = freq_double ? PER_W'(PWM_PERIOD_TICKS / 2) : PER_W'(PWM_PERIOD_TICKS);
        // R11: pseudo-random period stretch
        next_len = jitter_enable ? base_len + PER_W'(lfsr_reg) : base_len;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tick_cnt_reg <= '0;
            period_len_reg <= PER_W'(PWM_PERIOD_TICKS);
            lfsr_reg <= LFSR_SEED;
            period_start <= 1'b0;
        end
        else
        begin
            period_start <= 1'b0;
            if (div_reg == TICK_W'(PWM_CLK_CYCLES - 1))
            begin
                if (tick_cnt_reg >= period_len_reg - 1'b1)
                begin
                    tick_cnt_reg <= '0;
                    period_len_reg <= next_len;
                    lfsr_reg <= {lfsr_reg[1:0], lfsr_reg[2] ^ lfsr_reg[1]};
                    period_start <= 1'b1;
                end
                else
                    tick_cnt_reg <= tick_cnt_reg + 1'b1;
            end
        end
    end

endmodule

// file: verilog/hbp_half_bridge.sv
// One half-bridge gate controller: interlock, short protection, active diode.
// Assumes commanded high and low never both asserted by the loop.
`timescale 1ns/100ps
module hbp_half_bridge
    import hbp_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic cmd_high,
    input wire logic cmd_low,
    input wire logic reverse_high,
    input wire logic reverse_low,
    input wire logic overcurrent,
    input wire logic desat_high,
    input wire logic desat_low,
    output logic gate_high,
    output logic gate_low,
    output logic current_limit,
    output logic fault_high,
    output logic fault_low
);

    logic [DEAD_W-1:0] dead_reg;
    logic want_high;
    logic want_low;

    // R6: reverse current closes the idle switch
    always_comb
    begin
        want_high = (cmd_high || (reverse_high && !cmd_low)) && !fault_high;
        want_low = (cmd_low || (reverse_low && !cmd_high && !want_high)) && !fault_low;
    end

    // R3: break before make with dead time
    always_ff @(posedge clk)
    begin
        // R1: disabled means both gates off
        if (srst || !enable)
        begin
            gate_high <= 1'b0;
            gate_low <= 1'b0;
            // Dead time reloads here so a short enable dip keeps the interlock
            dead_reg <= DEAD_W'(DEAD_CYCLES);
        end
        else if (gate_high && !want_high)
        begin
            gate_high <= 1'b0;
            dead_reg <= DEAD_W'(DEAD_CYCLES);
        end
        else if (gate_low && !want_low)
        begin
            gate_low <= 1'b0;
            dead_reg <= DEAD_W'(DEAD_CYCLES);
        end
        else if (dead_reg != '0)
            dead_reg <= dead_reg - 1'b1;
        else if (want_high && !gate_low)
            gate_high <= 1'b1;
        else if (want_low && !gate_high)
            gate_low <= 1'b1;
    end

    // R4: first stage limits drive current
    always_ff @(posedge clk)
    begin
        if (srst || !enable)
            current_limit <= 1'b0;
        else
            current_limit <= overcurrent;
    end

    // R4: second stage latches transistor off
    always_ff @(posedge clk)
    begin
        if (srst || !enable)
        begin
            fault_high <= 1'b0;
            fault_low <= 1'b0;
        end
        else
        begin
            if (desat_high && gate_high)
                fault_high <= 1'b1;
            if (desat_low && gate_low)
                fault_low <= 1'b1;
        end
    end

endmodule

// file: verilog/hbp_bridge_ctrl.sv
// Top of the dual H-bridge current control: enable, PWM loop, gate drive.
// Assumes comparator, reverse-current and short sense inputs are synchronous.
// Half-bridges 0 and 1 form winding 0, half-bridges 2 and 3 winding 1.
`timescale 1ns/100ps
module hbp_bridge_ctrl
    import hbp_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic motor_drive_enable,
    input wire logic [SLOPE_W-1:0] slope_select,
    input wire logic pwm_double,
    input wire logic pwm_jitter,
    input wire logic [RANGE_W-1:0] current_range,
    input wire logic [POS_W-1:0] microstep_pos,
    input wire logic [N_WINDINGS-1:0] current_above,
    input wire logic [N_WINDINGS-1:0] winding_dir,
    input wire logic [N_HALF-1:0] reverse_high,
    input wire logic [N_HALF-1:0] reverse_low,
    input wire logic [N_HALF-1:0] overcurrent,
    input wire logic [N_HALF-1:0] desat_high,
    input wire logic [N_HALF-1:0] desat_low,
    output logic [N_HALF-1:0] gate_high,
    output logic [N_HALF-1:0] gate_low,
    output logic [N_HALF-1:0] current_limit,
    output logic [N_HALF-1:0] short_fault,
    output logic outputs_active,
    output logic [SLOPE_W-1:0] slope_code,
    output logic [N_WINDINGS-1:0] lowside_rds_high,
    output logic [N_WINDINGS-1:0] fast_decay,
    output logic [N_WINDINGS-1:0] pwm_on
);

    logic enable_reg;
    logic pwm_tick;
    logic period_start;
    logic [N_HALF-1:0] cmd_high;
    logic [N_HALF-1:0] cmd_low;
    logic [N_HALF-1:0] fault_high;
    logic [N_HALF-1:0] fault_low;
    hbp_reg_state_t state_reg [N_WINDINGS];
    logic [N_WINDINGS-1:0] above_all_reg;
    logic [5:0] amp_x;
    logic [5:0] amp_y;
    logic [5:0] amp [N_WINDINGS];

    // R1: enable taken from the control bit
    // R2: enable releases both bridges together
    always_ff @(posedge clk)
    begin
        if (srst)
            enable_reg <= 1'b0;
        else
            enable_reg <= motor_drive_enable;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            outputs_active <= 1'b0;
        else
            outputs_active <= enable_reg;
    end

    // R5: slope trim passed to gate drivers
    always_ff @(posedge clk)
    begin
        if (srst)
            slope_code <= SLOPE_RESET;
        else
            slope_code <= slope_select;
    end

    // R12: PWM timing from internal divider only
    hbp_pwm_clock u_pwm_clock (
        .clk(clk),
        .srst(srst),
        .freq_double(pwm_double),
        .jitter_enable(pwm_jitter),
        .pwm_tick(pwm_tick),
        .period_start(period_start)
    );

    // Coil amplitude index out of the 128-step circle
    always_comb
    begin
        amp_x = microstep_pos[5] ? AMP_FULL - {1'b0, microstep_pos[4:0]} : {1'b0, microstep_pos[4:0]};
        amp_y = AMP_FULL - amp_x;
        amp[0] = amp_x;
        amp[1] = amp_y;
    end

    genvar w;
    generate
        for (w = 0; w < N_WINDINGS; w++)
        begin : g_winding
            // R7: low-side resistance per coil, high side fixed
            always_ff @(posedge clk)
            begin
                if (srst)
                    lowside_rds_high[w] <= 1'b0;
                else
                    lowside_rds_high[w] <= (current_range < RANGE_LOW_THRESH) || (amp[w] < AMP_LOW_THRESH);
            end

            // Tracks whether the whole last period stayed above target
            always_ff @(posedge clk)
            begin
                if (srst || !enable_reg)
                    above_all_reg[w] <= 1'b0;
                else if (period_start)
                    above_all_reg[w] <= 1'b1;
                else if (!current_above[w])
                    above_all_reg[w] <= 1'b0;
            end

            // R8: comparator steers the decay loop
            // R9: transitions only on PWM clock ticks, except the drop to REG_OFF on disable
            always_ff @(posedge clk)
            begin
                // R13: disabled loop rests off
                if (srst || !enable_reg)
                    state_reg[w] <= REG_OFF;
                else if (period_start)
                begin
                    if (!current_above[w])
                        state_reg[w] <= REG_FORWARD;
                    else if (above_all_reg[w] && current_above[w])
                        state_reg[w] <= REG_FAST;
                    else
                        state_reg[w] <= REG_SLOW;
                end
                else if (pwm_tick)
                begin
                    case (state_reg[w])
                        REG_FORWARD:
                        begin
                            if (current_above[w])
                                state_reg[w] <= REG_SLOW;
                        end
                        REG_FAST:
                        begin
                            if (!current_above[w])
                                state_reg[w] <= REG_SLOW;
                        end
                        default:
                        begin
                            state_reg[w] <= state_reg[w];
                        end
                    endcase
                end
            end

            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    pwm_on[w] <= 1'b0;
                    fast_decay[w] <= 1'b0;
                end
                else
                begin
                    pwm_on[w] <= (state_reg[w] == REG_FORWARD);
                    fast_decay[w] <= (state_reg[w] == REG_FAST);
                end
            end

            // Forward drives along dir, slow shorts low sides, fast reverses
            always_comb
            begin
                cmd_high[2*w] = 1'b0;
                cmd_high[2*w+1] = 1'b0;
                cmd_low[2*w] = 1'b0;
                cmd_low[2*w+1] = 1'b0;
                case (state_reg[w])
                    REG_FORWARD:
                    begin
                        cmd_high[2*w] = winding_dir[w];
                        cmd_low[2*w+1] = winding_dir[w];
                        cmd_high[2*w+1] = !winding_dir[w];
                        cmd_low[2*w] = !winding_dir[w];
                    end
                    REG_SLOW:
                    begin
                        cmd_low[2*w] = 1'b1;
                        cmd_low[2*w+1] = 1'b1;
                    end
                    REG_FAST:
                    begin
                        cmd_high[2*w] = !winding_dir[w];
                        cmd_low[2*w+1] = !winding_dir[w];
                        cmd_high[2*w+1] = winding_dir[w];
                        cmd_low[2*w] = winding_dir[w];
                    end
                    default:
                    begin
                        cmd_high[2*w] = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

    genvar h;
    generate
        for (h = 0; h < N_HALF; h++)
        begin : g_half
            hbp_half_bridge u_half (
                .clk(clk),
                .srst(srst),
                .enable(enable_reg),
                .cmd_high(cmd_high[h]),
                .cmd_low(cmd_low[h]),
                .reverse_high(reverse_high[h]),
                .reverse_low(reverse_low[h]),
                .overcurrent(overcurrent[h]),
                .desat_high(desat_high[h]),
                .desat_low(desat_low[h]),
                .gate_high(gate_high[h]),
                .gate_low(gate_low[h]),
                .current_limit(current_limit[h]),
                .fault_high(fault_high[h]),
                .fault_low(fault_low[h])
            );

            // R4: short status, latched until disable
            always_ff @(posedge clk)
            begin
                if (srst)
                    short_fault[h] <= 1'b0;
                else
                    short_fault[h] <= fault_high[h] || fault_low[h];
            end
        end
    endgenerate

endmodule

// file: sim/hbp_winding_model.sv
// Behavioural pair of motor windings driven by the gate commands.
// Assumes half-bridges 2w and 2w+1 feed winding w; hold stalls slow decay.
`timescale 1ns/100ps
module hbp_winding_model
    import hbp_pkg::*;
(
    input wire logic clk,
    input wire logic hold,
    input wire logic [15:0] target,
    input wire logic [N_WINDINGS-1:0] winding_dir,
    input wire logic [N_HALF-1:0] gate_high,
    input wire logic [N_HALF-1:0] gate_low,
    output logic [N_WINDINGS-1:0] current_above
);
    int mag [N_WINDINGS] = '{0, 0};
    int t = 0;
    initial current_above = 2'h0;
    always @(posedge clk)
    begin
        t++;
        for (int w = 0; w < N_WINDINGS; w++)
        begin
            // current builds on forward path only
            if (gate_high[2*w+!winding_dir[w]] && gate_low[2*w+winding_dir[w]])
                mag[w] += 2;
            else if (gate_high[2*w+winding_dir[w]] && gate_low[2*w+!winding_dir[w]])
                mag[w] = mag[w] > 6 ? mag[w] - 6 : 0;
            else if (mag[w] > 0 && !hold && t % 8 == 0)
                mag[w]--;
            current_above[w] <= mag[w] > target;
        end
    end
endmodule

// file: sim/hbp_bridge_ctrl_asserts.sv
// Port assertions for the dual H-bridge control.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/100ps
module hbp_chk
    import hbp_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic motor_drive_enable,
    input wire logic [SLOPE_W-1:0] slope_select,
    input wire logic [N_HALF-1:0] overcurrent,
    input wire logic [N_HALF-1:0] desat_low,
    input wire logic [N_HALF-1:0] gate_high,
    input wire logic [N_HALF-1:0] gate_low,
    input wire logic [N_HALF-1:0] current_limit,
    input wire logic [N_HALF-1:0] short_fault,
    input wire logic outputs_active,
    input wire logic [SLOPE_W-1:0] slope_code,
    input wire logic [N_WINDINGS-1:0] fast_decay,
    input wire logic [N_WINDINGS-1:0] pwm_on
);
    logic [3:0] prv_reg;
    logic [4:0] cnt_reg;
    logic armed_reg;
    logic chg;
    assign chg = {pwm_on, fast_decay} != prv_reg;
    // First change after enable only arms, its phase is free
    always_ff @(posedge clk)
    begin
        prv_reg <= {pwm_on, fast_decay};
        cnt_reg <= chg ? 5'h1 : (cnt_reg == 5'(PWM_CLK_CYCLES - 1) ? 5'h0 : cnt_reg + 5'h1);
        armed_reg <= !srst && motor_drive_enable && (armed_reg || chg);
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    a_no_overlap:
        assert property ((gate_high & gate_low) == 4'h0) else $error("Both gates on");
    a_dead_high:
        assert property ($fell(gate_high[0]) |-> (!gate_low[0]) [*5]) else $error("Low gate in dead time");
    a_dead_low:
        assert property ($fell(gate_low[0]) |-> (!gate_high[0]) [*5]) else $error("High gate in dead time");
    a_off_disabled:
        assert property (!motor_drive_enable |-> ##2 (gate_high | gate_low) == 4'h0 && !outputs_active)
            else $error("Drive while disabled");
    a_on_enabled:
        assert property (motor_drive_enable [*3] |=> outputs_active) else $error("Bridges not enabled");
    a_slope_pass:
        assert property (!$past(srst) |-> slope_code == $past(slope_select)) else $error("Slope code wrong");
    a_limit_copy:
        assert property (motor_drive_enable [*3] |=> current_limit == $past(overcurrent))
            else $error("Current limit wrong");
    a_short_off:
        assert property (gate_low[1] && desat_low[1] && motor_drive_enable ##1 motor_drive_enable [*3]
            |-> short_fault[1] && !gate_low[1]) else $error("Short not switched off");
    a_loop_idle:
        assert property ((!motor_drive_enable) [*4] |-> (pwm_on | fast_decay) == 2'h0) else $error("Loop not idle");
    a_tick_grid:
        assert property (armed_reg && chg |-> cnt_reg == 5'h0) else $error("Switch point off grid");
endmodule
bind hbp_bridge_ctrl hbp_chk u_chk (.*);

// file: sim/tb.sv
// Self-checking bench: dual H-bridge control against a winding model.
// Assumes package, design, checker and model compiled first.
`timescale 1ns/100ps
module tb
    import hbp_pkg::*;
;
    localparam int BASE = PWM_PERIOD_TICKS * PWM_CLK_CYCLES;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic en = 1'b0;
    logic dbl = 1'b0;
    logic jit = 1'b0;
    logic hold = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [4:0] range = 5'h0;
    logic [6:0] pos = 7'h0;
    logic [1:0] dir = 2'h3;
    logic [3:0] ovc = 4'h0;
    logic [3:0] dsl = 4'h0;
    logic [3:0] rh = 4'h0;
    logic [3:0] rl = 4'h0;
    logic [15:0] target = 16'h3c;
    logic [1:0] above, slope, rds, fast, pon;
    logic [3:0] gh, gl, lim, flt;
    logic act;
    int num_errors = 0;
    int checks = 0;
    int n = 0;
    always #25 clk = ~clk;
    always @(posedge clk) n++;
    hbp_bridge_ctrl uut (.clk(clk), .srst(srst), .motor_drive_enable(en), .slope_select(sel),
        .pwm_double(dbl), .pwm_jitter(jit), .current_range(range), .microstep_pos(pos),
        .current_above(above), .winding_dir(dir), .reverse_high(rh), .reverse_low(rl),
        .overcurrent(ovc), .desat_high(4'h0), .desat_low(dsl), .gate_high(gh), .gate_low(gl),
        .current_limit(lim), .short_fault(flt), .outputs_active(act), .slope_code(slope),
        .lowside_rds_high(rds), .fast_decay(fast), .pwm_on(pon));
    hbp_winding_model wm (.clk(clk), .hold(hold), .target(target), .winding_dir(dir),
        .gate_high(gh), .gate_low(gl), .current_above(above));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic wait_pon(input logic v);
        int i;
        for (i = 0; i < 3000 && pon[0] !== v; i++)
            cyc(1);
        if (i == 3000)
        begin
            num_errors++;
            complete_run();
        end
    endtask
    // Time between two forward starts of winding 0
    task automatic period(output int p);
        int t0;
        wait_pon(1'b0);
        wait_pon(1'b1);
        t0 = n;
        wait_pon(1'b0);
        wait_pon(1'b1);
        p = n - t0;
    endtask
    initial
    begin
        int p;
        int x;
        int lo;
        int hi;
        p = $urandom(32'h3b56616e);
        cyc(10);
        srst = 1'b0;
        cyc(2);
        check({gh, gl, act, pon, fast}, 0, "idle");
        for (x = 0; x < 4; x++)
        begin
            sel = 2'(x);
            cyc(2);
            check(slope, x, "slope");
        end
        en = 1'b1;
        cyc(4);
        check(act, 1, "active");
        repeat (16)
        begin
            range = 5'($urandom);
            pos = 7'($urandom);
            cyc(3);
            x = pos[5] ? 32 - pos[4:0] : pos[4:0];
            check(rds, {range < 8 || 32 - x < 12, range < 8 || x < 12}, "rds");
        end
        period(p);
        check(p, BASE, "period");
        dbl = 1'b1;
        period(p);
        period(p);
        check(p, BASE / 2, "double");
        dbl = 1'b0;
        jit = 1'b1;
        period(p);
        lo = 9999;
        hi = 0;
        repeat (6)
        begin
            period(p);
            lo = p < lo ? p : lo;
            hi = p > hi ? p : hi;
            check(p % PWM_CLK_CYCLES, 0, "grid");
        end
        check(lo >= BASE && hi <= BASE + 7 * PWM_CLK_CYCLES && lo < hi, 1, "jitter");
        jit = 1'b0;
        hold = 1'b1;
        target = 16'h0;
        for (x = 0; x < 4000 && fast[0] !== 1'b1; x++)
            cyc(1);
        check(fast[0], 1, "fast");
        if (fast[0] !== 1'b1)
            complete_run();
        hold = 1'b0;
        target = 16'h3c;
        ovc = 4'($urandom);
        cyc(2);
        check(lim, ovc, "limit");
        for (x = 0; x < 3000 && gl[1] !== 1'b1; x++)
            cyc(1);
        if (x == 3000)
        begin
            num_errors++;
            complete_run();
        end
        dsl = 4'h2;
        cyc(3);
        check({flt[1], gl[1]}, 2'h2, "fault");
        dsl = 4'h0;
        cyc(40);
        check({flt[1], gl[1]}, 2'h2, "latched");
        en = 1'b0;
        cyc(4);
        check({gh, gl, pon, fast, flt, act}, 0, "off");
        srst = 1'b1;
        cyc(2);
        check(slope, 0, "reset");
        srst = 1'b0;
        en = 1'b1;
        cyc(3);
        check(fast, 0, "restart");
        rh = 4'h1;
        rl = 4'h4;
        cyc(8);
        check({gh, gl}, 8'h14, "diode on");
        rh = 4'h0;
        rl = 4'h0;
        cyc(2);
        check({gh, gl}, 0, "diode off");
        period(p);
        check(p, BASE, "resume");
        complete_run();
    end
endmodule
